// ---- core/biodc_pkg.sv ----
package biodc_pkg;
   localparam int          DATA_W      = 16;
   localparam int          ADDR_W      = 16;
   localparam int          PAGE_W      = 4;
   localparam int          PERIPH_N    = 5;
   // Module-site window and its halves
   localparam logic [15:0] MOD_LO      = 16'h0080;
   localparam logic [15:0] MOD_HI      = 16'h00BF;
   localparam int          MOD_GRP_BIT = 5;
   localparam int          MOD_OFF_W   = 5;
   localparam int          MOD_HALF    = 4;
   localparam logic [1:0]  CS_NONE     = 2'h0;
   localparam logic [1:0]  CS_FIRST    = 2'h1;
   localparam logic [1:0]  CS_SECOND   = 2'h2;
   localparam logic [1:0]  CS_BOTH     = 2'h3;
   // On-board peripheral window
   localparam logic [15:0] PER_LO      = 16'h00C0;
   localparam logic [15:0] PER_HI      = 16'h00DF;
   localparam int          PER_PIC_M   = 0;
   localparam int          PER_PIC_S   = 1;
   localparam int          PER_PAR     = 2;
   localparam int          PER_TMR     = 3;
   localparam int          PER_SER     = 4;
   // Special control ports
   localparam logic [15:0] SPC_LO      = 16'h00E0;
   localparam logic [15:0] SPC_HI      = 16'h00FF;
   localparam logic [15:0] IO_PROT_SW  = 16'h00CA;
   localparam logic [15:0] IO_SWRST    = 16'h00E0;
   localparam logic [15:0] IO_RSTCLR   = 16'h00E2;
   localparam logic [15:0] IO_MODE     = 16'h00E4;
   localparam logic [15:0] IO_BRKCLR   = 16'h00E6;
   localparam logic [15:0] IO_PARITY   = 16'h00E8;
   localparam logic [15:0] IO_BRDID    = 16'h00EC;
   localparam logic [15:0] IO_DPPAGE   = 16'h00EE;
   localparam logic [7:0]  SWRST_VAL   = 8'h01;
   localparam logic [7:0]  RSTCLR_VAL  = 8'h00;
   localparam logic [7:0]  BRKCLR_VAL  = 8'h00;
   localparam logic [3:0]  PAGE_RST    = 4'h0;
   // Coprocessor window
   localparam logic [15:0] DMA_LO      = 16'h0180;
   localparam logic [15:0] DMA_HI      = 16'h037F;
endpackage : biodc_pkg

// ---- core/biodc_decode.sv ----
`timescale 1ns/1ps
// Summary of operation
// - No expansion site fitted: 80H-0BFH cycles go to the backplane.
// - Byte access, even address 80H-8EH: first module select only.
// - Word access, even address 80H-8EH or 0A0H-0AEH, 16-bit module: both module selects together.
// - Byte access, odd address 81H-8FH or 0A1H-0AFH, 16-bit module: second module select only.
// - Byte access, 8-bit module, even 90H-9EH or 0B0H-0BEH: second module select.
// - Address groups go to their connectors; swap option exchanges them.
// - Byte chip selects at even ports 0C0H-0DEH for on-board peripherals.
// - Word write to 0CAH enters protected mode; byte read goes to port B.
// - Byte read of 0E4H returns addressing mode in bit 0.
// - Byte write of 0E4H sets mode from data bit 0.
// - Byte write of 01H to 0E0H starts a software reset.
// - Byte read of 0E0H returns reset-cause flag in bit 0.
// - Byte write of 00H to 0E2H clears the reset-cause flag.
// - Byte write of 0H to 0E6H clears the break-detect interrupt.
// - Any byte write to 0E8H clears the parity-error interrupt.
// - Byte read of 0E8H arms a parity error on next memory access.
// - Word read of 0ECH returns board ID; byte write 0EEH selects page.
// - Cycles arriving from the backplane are never claimed on board.
// - Without the coprocessor, 180H-37FH goes to the backplane.
// - Dual-port disabled while start address exceeds end address.
// - Dual-port start and end do not depend on the page.
// - Page select is 4 bits, 0H-FH valid, resets to 0H.
module biodc_decode
   import biodc_pkg::*;
#(
   parameter int DP_AW = 16
) (
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   input  wire logic                        ioReq,
   input  wire logic                        ioWrite,
   input  wire logic                        ioWord,
   input  wire logic                        ioFromBackplane,
   input  wire logic [biodc_pkg::ADDR_W-1:0] ioAddr,
   input  wire logic [biodc_pkg::DATA_W-1:0] ioWrData,
   input  wire logic [1:0]                  siteFitted,
   input  wire logic [1:0]                  siteWide,
   input  wire logic                        swapSites,
   input  wire logic                        dmaFitted,
   input  wire logic [biodc_pkg::DATA_W-1:0] boardIdIn,
   input  wire logic [DP_AW-1:0]            dpStartAddr,
   input  wire logic [DP_AW-1:0]            dpEndAddr,
   input  wire logic                        localMemAccess,
   input  wire logic                        breakDetect,
   input  wire logic                        parityErrDetect,
   output logic                             ioAck_q,
   output logic [biodc_pkg::DATA_W-1:0]     ioRdData_q,
   output logic                             bpIoReq_q,
   output logic [1:0]                       modCsConn0_q,
   output logic [1:0]                       modCsConn1_q,
   output logic [biodc_pkg::PERIPH_N-1:0]   periphCs_q,
   output logic [1:0]                       periphReg_q,
   output logic                             dmaIoCs_q,
   output logic                             protectedMode_q,
   output logic                             softResetPulse_q,
   output logic                             resetCause_q,
   output logic                             breakIrq_q,
   output logic                             parityIrq_q,
   output logic [biodc_pkg::PAGE_W-1:0]     dpPageNum_q,
   output logic                             dpEnabled_q
);
   import biodc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : inRange

   // Module selects from offset within a 32-port group
   function automatic logic [1:0] modCs(input logic [MOD_OFF_W-1:0] off,
                                        input logic word, input logic wide);
      logic [1:0] cs;
      cs = CS_NONE;
      if (!off[MOD_HALF] && !off[0]) begin
         cs = (word && wide) ? CS_BOTH : CS_FIRST;
      end else if (!off[MOD_HALF] && off[0]) begin
         cs = (wide && !word) ? CS_SECOND : CS_NONE;
      end else if (off[MOD_HALF] && !off[0]) begin
         cs = (!wide && !word) ? CS_SECOND : CS_NONE;
      end
      return cs;
   endfunction : modCs

   ////////////////////////////////////////////////////////////////////////////
   logic                  accept;
   logic                  connSel;
   logic [1:0]            mcs;
   logic [7:0]            wrByte;
   logic                  byteWr;
   logic                  byteRd;
   logic                  parityArm_q;
   logic                  parityArm_d;
   logic                  ioAck_d;
   logic [DATA_W-1:0]     ioRdData_d;
   logic                  bpIoReq_d;
   logic [1:0]            modCsConn0_d;
   logic [1:0]            modCsConn1_d;
   logic [PERIPH_N-1:0]   periphCs_d;
   logic [1:0]            periphReg_d;
   logic                  dmaIoCs_d;
   logic                  protectedMode_d;
   logic                  softResetPulse_d;
   logic                  resetCause_d;
   logic                  breakIrq_d;
   logic                  parityIrq_d;
   logic [PAGE_W-1:0]     dpPageNum_d;
   logic                  dpEnabled_d;

   always_comb begin
      // Backplane-originated cycles are never ours
      // backplane cycles ignored
      accept           = ioReq && !ioFromBackplane;
      connSel          = ioAddr[MOD_GRP_BIT] ^ swapSites;
      mcs              = modCs(ioAddr[MOD_OFF_W-1:0], ioWord, siteWide[connSel]);
      wrByte           = ioWrData[7:0];
      byteWr           = ioWrite && !ioWord;
      byteRd           = !ioWrite && !ioWord;
      ioAck_d          = 1'b0;
      ioRdData_d       = '0;
      bpIoReq_d        = 1'b0;
      modCsConn0_d     = CS_NONE;
      modCsConn1_d     = CS_NONE;
      periphCs_d       = '0;
      periphReg_d      = periphReg_q;
      dmaIoCs_d        = 1'b0;
      protectedMode_d  = protectedMode_q;
      softResetPulse_d = 1'b0;
      resetCause_d     = resetCause_q;
      breakIrq_d       = breakIrq_q;
      parityIrq_d      = parityIrq_q;
      parityArm_d      = parityArm_q && !localMemAccess;
      dpPageNum_d      = dpPageNum_q;
      if (accept) begin
         if (inRange(ioAddr, MOD_LO, MOD_HI)) begin
            if (siteFitted == 2'h0) begin
               bpIoReq_d = 1'b1;
            end else if (siteFitted[connSel] && (mcs != CS_NONE)) begin
               ioAck_d = 1'b1;
               if (connSel) begin
                  modCsConn1_d = mcs;
               end else begin
                  modCsConn0_d = mcs;
               end
            end else begin
               bpIoReq_d = 1'b1;
            end
         end else if (inRange(ioAddr, PER_LO, PER_HI)) begin
            ioAck_d = 1'b1;
            if (ioAddr == IO_PROT_SW && ioWord && ioWrite) begin
               protectedMode_d = 1'b1;
            end else if (!ioAddr[0] && !ioWord) begin
               periphReg_d = ioAddr[2:1];
               case (ioAddr[4:3])
                  2'h0:    periphCs_d[ioAddr[2] ? PER_PIC_S : PER_PIC_M] = 1'b1;
                  2'h1:    periphCs_d[PER_PAR] = 1'b1;
                  2'h2:    periphCs_d[PER_TMR] = 1'b1;
                  default: periphCs_d[PER_SER] = 1'b1;
               endcase
            end
         end else if (inRange(ioAddr, SPC_LO, SPC_HI)) begin
            ioAck_d = 1'b1;
            case (ioAddr)
               IO_SWRST: begin
                  if (byteWr && wrByte == SWRST_VAL) begin
                     softResetPulse_d = 1'b1;
                     resetCause_d     = 1'b1;
                  end
                  if (byteRd) begin
                     ioRdData_d[0] = resetCause_q;
                  end
               end
               IO_RSTCLR: begin
                  if (byteWr && wrByte == RSTCLR_VAL) begin
                     resetCause_d = 1'b0;
                  end
               end
               IO_MODE: begin
                  if (byteWr) begin
                     protectedMode_d = wrByte[0];
                  end
                  if (byteRd) begin
                     ioRdData_d[0] = protectedMode_q;
                  end
               end
               IO_BRKCLR: begin
                  if (byteWr && wrByte == BRKCLR_VAL) begin
                     breakIrq_d = 1'b0;
                  end
               end
               IO_PARITY: begin
                  if (byteWr) begin
                     parityIrq_d = 1'b0;
                  end
                  if (byteRd) begin
                     parityArm_d = 1'b1;
                  end
               end
               IO_BRDID: begin
                  if (ioWord && !ioWrite) begin
                     ioRdData_d = boardIdIn;
                  end
               end
               IO_DPPAGE: begin
                  if (byteWr) begin
                     dpPageNum_d = wrByte[PAGE_W-1:0];
                  end
               end
               default: ioRdData_d = '0;
            endcase
         end else if (inRange(ioAddr, DMA_LO, DMA_HI)) begin
            if (dmaFitted) begin
               dmaIoCs_d = 1'b1;
            end else begin
               bpIoReq_d = 1'b1;
            end
         end else begin
            bpIoReq_d = 1'b1;
         end
      end
      // Events win over a clear in the same cycle
      breakIrq_d  = breakIrq_d | breakDetect;
      parityIrq_d = parityIrq_d | parityErrDetect | (parityArm_q && localMemAccess);
      dpEnabled_d = (dpStartAddr <= dpEndAddr);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ioAck_q          <= 1'b0;
         ioRdData_q       <= '0;
         bpIoReq_q        <= 1'b0;
         modCsConn0_q     <= CS_NONE;
         modCsConn1_q     <= CS_NONE;
         periphCs_q       <= '0;
         periphReg_q      <= 2'h0;
         dmaIoCs_q        <= 1'b0;
         softResetPulse_q <= 1'b0;
         protectedMode_q  <= 1'b0;
         resetCause_q     <= 1'b0;
         breakIrq_q       <= 1'b0;
         parityIrq_q      <= 1'b0;
         parityArm_q      <= 1'b0;
         dpPageNum_q      <= PAGE_RST;
         dpEnabled_q      <= 1'b0;
      end else begin
         ioAck_q          <= ioAck_d;
         ioRdData_q       <= ioRdData_d;
         bpIoReq_q        <= bpIoReq_d;
         modCsConn0_q     <= modCsConn0_d;
         modCsConn1_q     <= modCsConn1_d;
         periphCs_q       <= periphCs_d;
         periphReg_q      <= periphReg_d;
         dmaIoCs_q        <= dmaIoCs_d;
         softResetPulse_q <= softResetPulse_d;
         protectedMode_q  <= protectedMode_d;
         resetCause_q     <= resetCause_d;
         breakIrq_q       <= breakIrq_d;
         parityIrq_q      <= parityIrq_d;
         parityArm_q      <= parityArm_d;
         dpPageNum_q      <= dpPageNum_d;
         dpEnabled_q      <= dpEnabled_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   logic rdSw;
   logic wrSw;
   assign rdSw = accept && byteRd;
   assign wrSw = accept && byteWr;

   AST_EMPTY_SITES_FWD: assert property (
      accept && inRange(ioAddr, MOD_LO, MOD_HI) && siteFitted == 2'h0
      |=> bpIoReq_q && !ioAck_q && modCsConn0_q == CS_NONE && modCsConn1_q == CS_NONE)
      else $error("empty sites not forwarded");
   AST_BYTE_EVEN_FIRST: assert property (
      wrSw && ioAddr >= MOD_LO && ioAddr < MOD_LO + 16'h0010 && !ioAddr[0]
      && siteFitted == 2'h3 && !swapSites |=> modCsConn0_q == CS_FIRST)
      else $error("even byte did not give first select");
   AST_WORD_BOTH: assert property (
      accept && ioWord && !ioAddr[0] && ioAddr[7:4] == 4'hA && siteFitted == 2'h3
      && ioAddr[15:8] == 8'h00
      && siteWide == 2'h3 && !swapSites |=> modCsConn1_q == CS_BOTH && ioAck_q)
      else $error("word access did not give both selects");
   AST_ODD_SECOND: assert property (
      rdSw && ioAddr[7:4] == 4'h8 && ioAddr[0] && siteFitted[0] && siteWide[0]
      && ioAddr[15:8] == 8'h00
      && !swapSites |=> modCsConn0_q == CS_SECOND)
      else $error("odd byte did not give second select");
   AST_NARROW_HIGH: assert property (
      wrSw && ioAddr[7:4] == 4'hB && !ioAddr[0] && siteFitted[0] && !siteWide[0]
      && ioAddr[15:8] == 8'h00
      && swapSites |=> modCsConn0_q == CS_SECOND && modCsConn1_q == CS_NONE)
      else $error("8-bit high half select wrong");
   AST_PERIPH_TIMER: assert property (
      rdSw && ioAddr[7:3] == 5'h1A && !ioAddr[0] && ioAddr[15:8] == 8'h00
      |=> periphCs_q == 5'h08 && periphReg_q == $past(ioAddr[2:1]))
      else $error("timer select wrong");
   AST_PROT_SWITCH: assert property (
      accept && ioWrite && ioWord && ioAddr == IO_PROT_SW |=> protectedMode_q && ioAck_q)
      else $error("word write did not enter protected mode");
   AST_MODE_RW: assert property (
      wrSw && ioAddr == IO_MODE ##1 rdSw && ioAddr == IO_MODE
      |=> ioRdData_q[0] == $past(ioWrData[0], 2))
      else $error("mode bit readback mismatch");
   AST_SWRST_CAUSE: assert property (
      wrSw && ioAddr == IO_SWRST && ioWrData[7:0] == SWRST_VAL
      |=> softResetPulse_q && resetCause_q ##1 (!softResetPulse_q
      || $past(wrSw && ioAddr == IO_SWRST && ioWrData[7:0] == SWRST_VAL)))
      else $error("software reset not one pulse with flag");
   AST_CAUSE_CLEAR: assert property (
      wrSw && ioAddr == IO_RSTCLR && ioWrData[7:0] == RSTCLR_VAL |=> !resetCause_q)
      else $error("reset cause not cleared");
   AST_BREAK_CLEAR: assert property (
      wrSw && ioAddr == IO_BRKCLR && ioWrData[7:0] == BRKCLR_VAL && !breakDetect
      |=> !breakIrq_q)
      else $error("break interrupt not cleared");
   AST_PARITY_ARM: assert property (
      rdSw && ioAddr == IO_PARITY ##1 localMemAccess |=> parityIrq_q)
      else $error("armed parity error did not fire");
   AST_BACKPLANE_IGNORED: assert property (
      ioReq && ioFromBackplane && !(ioReq && !ioFromBackplane) |=> !ioAck_q && !bpIoReq_q)
      else $error("backplane cycle claimed");
   AST_DMA_FWD: assert property (
      accept && !dmaFitted && inRange(ioAddr, DMA_LO, DMA_HI) |=> bpIoReq_q && !dmaIoCs_q)
      else $error("coprocessor window not forwarded");
   AST_DP_DISABLED: assert property (
      dpStartAddr > dpEndAddr |=> !dpEnabled_q)
      else $error("dual-port enabled with start above end");

   COV_SWRST: cover property (wrSw && ioAddr == IO_SWRST ##1 softResetPulse_q);
   COV_MOD_WORD: cover property (modCsConn0_q == CS_BOTH || modCsConn1_q == CS_BOTH);
   COV_PARITY: cover property (parityArm_q && localMemAccess ##1 parityIrq_q);
endmodule : biodc_decode

// ---- verif/biodc_host.sv ----
`timescale 1ns/1ps
module biodc_host (
   output logic        ioReq,
   output logic        ioWrite,
   output logic        ioWord,
   output logic        ioFromBackplane,
   output logic [15:0] ioAddr,
   output logic [15:0] ioWrData
);
   ////////////////////////////////////////////////////////////
   // One cycle, local or backplane, changed off the sampling edge
   task automatic drive(input logic r, w, wd, b, input logic [15:0] a, d);
      ioReq = r;
      ioWrite = w;
      ioWord = wd;
      ioFromBackplane = b;
      // Idle lines carry the complement of the given address and data
      ioAddr = r ? a : ~a;
      ioWrData = r ? d : ~d;
   endtask : drive
endmodule : biodc_host

// ---- verif/tb_board_io_decode_and_control_regs.sv ----
`timescale 1ns/1ps
module tb_board_io_decode_and_control_regs;
   import biodc_pkg::*;
   logic        sys_clk = 1'h0;
   logic        reset, lma, brk, perr, swap, dmaF, ack, bp, dmaCs, swr;
   logic        mode, cause, bIrq, pIrq, dpEn, ioReq, ioWrite, ioWord, ioFromBp;
   logic        mM, cM, bM, pM, armM, enM, rq, w, wd, fb;
   logic [1:0]  fit, wide, cs0, cs1, preg, rgM;
   logic [3:0]  page, pgM;
   logic [4:0]  pcs;
   logic [15:0] ioAddr, ioWrData, rd, bid, dpS, dpE, a, d;
   logic [31:0] r;
   int          error_cnt, checked, seed;
   int          cyc = 0;
   // Events, req/wr/word/backplane, address, data
   logic [39:0] dirOps [0:36] = '{
      40'h0_C_00E0_0001, 40'h0_8_00E0_0000, 40'h0_C_00E2_0001, 40'h0_8_00E0_0000,
      40'h0_C_00E2_0000, 40'h0_8_00E0_0000, 40'h0_C_00E4_0001, 40'h0_8_00E4_0000,
      40'h0_C_00E4_0000, 40'h0_E_00CA_1234, 40'h0_8_00CA_0000, 40'h0_8_00E4_0000,
      40'h0_D_00E4_0000, 40'h0_8_00E4_0000, 40'h0_C_00EE_0003, 40'h0_D_00EE_0001,
      40'h0_C_00EE_000F, 40'h0_A_00EC_0000, 40'h0_8_00EA_0000, 40'h0_E_00F6_BEEF,
      40'h4_0_0000_0000, 40'h0_C_00E6_0005, 40'h4_C_00E6_0000, 40'h0_C_00E6_0000,
      40'h1_0_0000_0000, 40'h2_C_00E8_00A5, 40'h0_C_00E8_005A, 40'h1_8_00E8_0000,
      40'h1_0_0000_0000, 40'h0_C_00E8_0000, 40'h1_0_0000_0000, 40'h0_8_00C6_0000,
      40'h0_8_00C7_0000, 40'h0_E_00A0_1111, 40'h0_8_0081_0000, 40'h0_8_0200_0000,
      40'h0_8_0010_0000};
   biodc_host u_host (.ioReq(ioReq), .ioWrite(ioWrite), .ioWord(ioWord),
      .ioFromBackplane(ioFromBp), .ioAddr(ioAddr), .ioWrData(ioWrData));
   biodc_decode u_dut (
      .sys_clk(sys_clk), .reset(reset), .ioReq(ioReq), .ioWrite(ioWrite), .ioWord(ioWord),
      .ioFromBackplane(ioFromBp), .ioAddr(ioAddr), .ioWrData(ioWrData), .siteFitted(fit),
      .siteWide(wide), .swapSites(swap), .dmaFitted(dmaF), .boardIdIn(bid), .dpStartAddr(dpS),
      .dpEndAddr(dpE), .localMemAccess(lma), .breakDetect(brk), .parityErrDetect(perr),
      .ioAck_q(ack), .ioRdData_q(rd), .bpIoReq_q(bp), .modCsConn0_q(cs0), .modCsConn1_q(cs1),
      .periphCs_q(pcs), .periphReg_q(preg), .dmaIoCs_q(dmaCs), .protectedMode_q(mode),
      .softResetPulse_q(swr), .resetCause_q(cause), .breakIrq_q(bIrq), .parityIrq_q(pIrq),
      .dpPageNum_q(page), .dpEnabled_q(dpEn));
   ////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      checked = checked + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic conclude();
      if (error_cnt == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   // Reference for one clock edge, then compare
   task automatic step(input string n);
      logic [12:0] ep, pg;
      logic [11:0] se, sg;
      logic [15:0] ed;
      logic        dk, f, r8, cb, cp, c;
      logic [1:0]  cs;
      logic [4:0]  o;
      int          k;
      {ep, ed, r8, cb, cp, cs} = '0;
      dk = 1'h1;
      f = armM & lma;
      if (reset) begin
         {mM, cM, bM, pM, armM, enM, pgM, rgM} = '0;
      end else begin
         if (ioReq && !ioFromBp) begin
            if (ioAddr >= MOD_LO && ioAddr <= MOD_HI) begin
               c = ioAddr[5] ^ swap;
               o = ioAddr[4:0];
               if (!fit[c]) ep[11] = 1'h1;
               else begin
                  {ep[12], dk} = 2'h2;
                  if (ioWord && !o[0] && !o[4] && wide[c]) cs = CS_BOTH;
                  else if (!o[0] && !o[4]) cs = CS_FIRST;
                  else if (!ioWord && (o[0] ? !o[4] && wide[c] : o[4] && !wide[c])) cs = CS_SECOND;
                  else {ep[12], ep[11]} = 2'h1;
                  if (c) ep[7:6] = cs;
                  else ep[9:8] = cs;
               end
            end else if (ioAddr >= PER_LO && ioAddr <= PER_HI) begin
               ep[12] = 1'h1;
               if (ioWord && ioWrite && ioAddr == IO_PROT_SW) {mM, dk} = 2'h2;
               else if (!ioWord && !ioAddr[0]) begin
                  k = ioAddr < 16'h00C4 ? PER_PIC_M : ioAddr < 16'h00C8 ? PER_PIC_S :
                      ioAddr < 16'h00D0 ? PER_PAR : ioAddr < 16'h00D8 ? PER_TMR : PER_SER;
                  {ep[1 + k], dk} = 2'h2;
                  rgM = ioAddr[2:1];
               end
            end else if (ioAddr >= SPC_LO && ioAddr <= SPC_HI) begin
               {ep[12], dk} = {1'h1, !ioWrite};
               case (ioAddr)
                  IO_SWRST: if (!ioWrite) ed[0] = cM;
                     else if (ioWrData[7:0] == SWRST_VAL) {ep[0], cM} = 2'h3;
                  IO_RSTCLR: if (ioWrData[7:0] == RSTCLR_VAL) cM = 1'h0;
                  IO_MODE: if (ioWrite) mM = ioWrData[0];
                     else ed[0] = mM;
                  IO_BRKCLR: cb = ioWrData[7:0] == BRKCLR_VAL;
                  IO_PARITY: if (ioWrite) cp = 1'h1;
                     else {r8, dk} = 2'h2;
                  IO_BRDID: ed = bid;
                  IO_DPPAGE: pgM = ioWrData[3:0];
                  default: ;
               endcase
            end else if (ioAddr >= DMA_LO && ioAddr <= DMA_HI && dmaF) ep[10] = 1'h1;
            else ep[11] = 1'h1;
         end
         armM = r8 | (armM & !f);
         bM = (bM & !cb) | brk;
         pM = (pM & !cp) | perr | f;
         enM = dpS <= dpE;
      end
      @(negedge sys_clk);
      pg = {ack, bp, dmaCs, cs0, cs1, pcs, swr};
      se = {enM, mM, cM, bM, pM, pgM, rgM};
      sg = {dpEn, mode, cause, bIrq, pIrq, page, preg};
      check({n, " pulses"}, 32'(ep), 32'(pg));
      if (dk) check({n, " data"}, 32'(ed), 32'(rd));
      check({n, " state"}, 32'(se), 32'(sg));
   endtask : step
   ////////////////////////////////////////////////////////////
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         conclude();
      end
   end
   initial begin
      {error_cnt, checked} = '0;
      seed = 32'h85399A4A;
      {reset, lma, brk, perr, swap, dmaF, fit, wide} = 10'h200;
      {dpS, dpE} = {16'h0010, 16'h0000};
      bid = 16'($random(seed));
      u_host.drive(1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h0000);
      repeat (12) step("reset");
      {reset, fit, wide, dmaF} = 6'h1F;
      foreach (dirOps[i]) begin
         {brk, perr, lma} = dirOps[i][38:36];
         r = $random(seed);
         {a, d} = dirOps[i][35] ? dirOps[i][31:0] : r;
         u_host.drive(dirOps[i][35], dirOps[i][34], dirOps[i][33], dirOps[i][32], a, d);
         step("directed");
      end
      reset = 1'h1;
      repeat (2) step("midreset");
      reset = 1'h0;
      repeat (3000) begin
         r = $random(seed);
         a = 16'($random(seed));
         d = 16'($random(seed));
         {fit, wide, swap, dmaF} = r[5:0];
         {dpS, dpE} = {14'h0000, r[17:16], 14'h0000, r[19:18]};
         {brk, perr, lma} = {r[11:8] == 4'h0, r[15:12] == 4'h0, r[6]};
         {rq, w, wd, fb} = {r[23] | r[24], r[25], r[26], r[22:20] == 3'h0};
         case (r[28:27])
            2'h0: a = a & 16'h00FF;
            2'h1: a = 16'h0080 | (a & 16'h003F);
            2'h2: a = 16'h0100 + (a & 16'h02FF);
            default: ;
         endcase
         if (d[15]) d = d & 16'h0001;
         if (a >= SPC_LO && a < 16'h00F0 && a != 16'h00EA) begin
            a[0] = 1'h0;
            if (a == IO_BRDID) {w, wd} = 2'h1;
            else wd = 1'h0;
            if (a == IO_RSTCLR || a == IO_BRKCLR || a == IO_DPPAGE) w = 1'h1;
         end
         u_host.drive(rq, w, wd, fb, a, d);
         step("random");
      end
      conclude();
   end
endmodule : tb_board_io_decode_and_control_regs
